// ==== verilog/isss_spi_slave.sv ====
// Summary of operation
// - the link runs with clock idling high and data captured on the rising clock edge.
// - the top bit of the output word is driven when chip select falls, before any clock edge.
// - each later output bit is shifted out after a falling edge of the serial clock.
// - data in is sampled on rising serial clock edges while chip select is low.
// - data out is released whenever chip select is high.
module isss_spi_slave
  import isss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  input  wire logic [WORD_W-1:0] tx_word,
  input  wire logic [7:0]        sample_period_setting,
  output logic [WORD_W-1:0]      rx_word,
  output logic                   rx_valid,
  output logic                   fast_mode
);

  logic [2:0] sclk_s_q;
  logic [2:0] cs_s_q;
  logic [1:0] din_s_q;
  logic [2:0] sclk_s_d;
  logic [2:0] cs_s_d;
  logic [1:0] din_s_d;
  // stage 2 is a history bit for edge detection, not read from stage 0
  always_comb begin
    sclk_s_d = {sclk_s_q[1:0], sclk};
    cs_s_d   = {cs_s_q[1:0], cs_n};
    din_s_d  = {din_s_q[0], din};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s_q <= 3'h7;
      cs_s_q   <= 3'h7;
      din_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= sclk_s_d;
      cs_s_q   <= cs_s_d;
      din_s_q  <= din_s_d;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_high;
  assign cs_high   = cs_s_q[1];
  assign cs_fall   = cs_s_q[2] & ~cs_s_q[1];
  // mode 3: idle high, capture on rise, launch on fall
  assign sclk_rise = ~sclk_s_q[2] & sclk_s_q[1] & ~cs_high;
  assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1] & ~cs_high;

  isss_state_t       st_q;
  isss_state_t       st_d;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] tx_d;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] rx_d;
  logic [WORD_W-1:0] rxo_q;
  logic [WORD_W-1:0] rxo_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              dout_d;
  logic              oe_d;
  logic              rxv_d;
  logic              fast_d;
  logic              first_q;
  logic              first_d;

  // shared by both shift registers: msb leaves first, new bit enters at the bottom
  function automatic logic [WORD_W-1:0] isss_shl(input logic [WORD_W-1:0] w, input logic b);
    return {w[WORD_W-2:0], b};
  endfunction : isss_shl

  always_comb begin
    st_d    = st_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    rxo_d   = rxo_q;
    cnt_d   = cnt_q;
    first_d = first_q;
    dout_d  = dout;
    oe_d    = dout_oe;
    rxv_d   = 1'b0;
    fast_d  = (sample_period_setting <= FAST_MAX_SET);
    unique case (st_q)
      ISSS_IDLE: begin
        oe_d = 1'b0;
        if (cs_fall) begin
          st_d    = ISSS_XFER;
          tx_d    = tx_word;
          dout_d  = tx_word[WORD_W-1];
          oe_d    = 1'b1;
          cnt_d   = '0;
          first_d = 1'b1;
        end
      end
      ISSS_XFER: begin
        if (cs_high) begin
          st_d   = ISSS_IDLE;
          oe_d   = 1'b0;
        end else begin
          if (sclk_fall) begin
            // first fall only opens the frame; the top bit is already out
            if (!first_q) begin
              tx_d   = isss_shl(tx_q, 1'b0);
              dout_d = tx_q[WORD_W-2];
            end
            first_d = 1'b0;
          end
          if (sclk_rise) begin
            rx_d    = isss_shl(rx_q, din_s_q[1]);
            first_d = 1'b0;
            if (cnt_q == CNT_W'(WORD_W - 1)) begin
              cnt_d = '0;
              rxo_d = isss_shl(rx_q, din_s_q[1]);
              rxv_d = 1'b1;
            end else begin
              cnt_d = cnt_q + CNT_W'(1);
            end
          end
        end
      end
      default: st_d = ISSS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= ISSS_IDLE;
      tx_q      <= TX_RESET_WORD;
      rx_q      <= '0;
      rxo_q     <= '0;
      cnt_q     <= '0;
      first_q   <= 1'b0;
      dout      <= 1'b0;
      dout_oe   <= 1'b0;
      rx_valid  <= 1'b0;
      fast_mode <= 1'b0;
    end else begin
      st_q      <= st_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      rxo_q     <= rxo_d;
      cnt_q     <= cnt_d;
      first_q   <= first_d;
      dout      <= dout_d;
      dout_oe   <= oe_d;
      rx_valid  <= rxv_d;
      fast_mode <= fast_d;
    end
  end
  assign rx_word = rxo_q;

  a_oe_off_idle: assert property (@(posedge clk) disable iff (!arst_n)
    cs_s_q[1] && $past(cs_s_q[1]) |-> ##1 !dout_oe)
    else $error("data out driven while chip select high");
  a_msb_at_cs: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_IDLE) && cs_fall |=> dout_oe && dout == $past(tx_word[WORD_W-1]))
    else $error("top bit not driven at chip select fall");
  a_shift_on_fall: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !cs_high && sclk_fall && !first_q |=> dout == $past(tx_q[WORD_W-2]))
    else $error("output bit not shifted after falling clock");
  a_sample_rise: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !cs_high && sclk_rise |=> rx_q[0] == $past(din_s_q[1]))
    else $error("input bit not sampled on rising clock");
  a_ignore_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_IDLE) && !cs_fall |=> $stable(rx_q) && !rx_valid)
    else $error("activity taken while chip select high");
  a_mode3_idle: assert property (@(posedge clk) disable iff (!arst_n)
    cs_fall |-> !sclk_fall && !sclk_rise)
    else $error("clock edge seen at chip select fall");

  a_oe_in_xfer: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !cs_high |=> dout_oe)
    else $error("data out not driven during transfer");

  a_oe_drop_cs: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && cs_high |=> !dout_oe && (st_q == ISSS_IDLE))
    else $error("data out not released when chip select rose");

  a_idle_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_IDLE) && !cs_fall |=> !dout_oe)
    else $error("data out driven while idle");

  a_first_fall_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !cs_high && sclk_fall && first_q |=> $stable(dout))
    else $error("top bit lost at first falling clock");

  a_dout_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !sclk_fall |=> $stable(dout))
    else $error("data out changed without falling clock");

  a_tx_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !sclk_fall |=> $stable(tx_q))
    else $error("output word shifted without falling clock");

  a_rx_shift: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_XFER) && !cs_high && sclk_rise |=> rx_q[WORD_W-1:1] == $past(rx_q[WORD_W-2:0]))
    else $error("input word not shifted on rising clock");

  a_valid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    rx_valid |=> !rx_valid)
    else $error("word valid longer than one cycle");

  a_valid_count: assert property (@(posedge clk) disable iff (!arst_n)
    rx_valid |-> $past(cnt_q) == CNT_W'(WORD_W - 1))
    else $error("word valid before the last bit");

  a_word_on_valid: assert property (@(posedge clk) disable iff (!arst_n)
    rx_valid |-> rx_word == rx_q)
    else $error("received word differs from shift register");

  a_word_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !rx_valid |-> $stable(rx_word))
    else $error("received word changed without valid");

  a_count_restart: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == ISSS_IDLE) && cs_fall |=> (cnt_q == '0) && first_q)
    else $error("bit count not restarted at chip select fall");
endmodule : isss_spi_slave

// ==== verilog/isss_pkg.sv ====
package isss_pkg;
  localparam int          WORD_W        = 16;
  localparam int          CNT_W         = 5;
  localparam int          CLK_MHZ       = 250;
  localparam int          CS_LEAD_NS10  = 488;  // tenths of ns, chip select to clock edge
  localparam int          CS_LEAD_CYC   = (CS_LEAD_NS10 * CLK_MHZ + 9999) / 10000;
  localparam logic [7:0]  FAST_MAX_SET  = 8'h07;
  localparam logic [15:0] TX_RESET_WORD = 16'h0000;
  typedef enum logic [1:0] {
    ISSS_IDLE  = 2'b00,
    ISSS_XFER  = 2'b01
  } isss_state_t;
endpackage : isss_pkg

// ==== verif/isss_master_model.sv ====
module isss_master_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input int n, input int gap);
    cs_n <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      din <= w[15-i];
      repeat (8) @(posedge clk);
      got[15-i] = dout_oe ? dout : 1'bz;
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
    end
    cs_n <= 1'b1;
    din <= ~din;
    repeat (gap) @(posedge clk);
  endtask : xfer
endmodule : isss_master_model

// ==== verif/isss_spi_slave_test.sv ====
module isss_spi_slave_test;
  import isss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, arst_n, sclk, cs_n, din, dout, dout_oe, rx_valid, fast_mode;
  logic [WORD_W-1:0] tx_word, rx_word;
  logic [7:0]        sample_period_setting;
  int                bad_count = 0, tests_run = 0, pulses = 0;
  isss_master_model i_mst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe));
  isss_spi_slave i_dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .tx_word(tx_word), .rx_word(rx_word),
    .sample_period_setting(sample_period_setting), .rx_valid(rx_valid),
    .fast_mode(fast_mode));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (rx_valid === 1'b1) pulses <= pulses + 1;
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic frame(logic [7:0] set, logic [15:0] tx, logic [15:0] rx, int gap);
    int p0;
    p0 = pulses;
    sample_period_setting <= set;
    tx_word <= tx;
    i_mst.xfer(rx, 16, gap);
    chk("fast_mode", 16'(fast_mode), 16'(set <= 8'h07));
    chk("dout", i_mst.got, tx);
    chk("rx_word", rx_word, rx);
    chk("rx_valid", 16'(pulses - p0), 16'h0001);
    chk("dout_oe", 16'(dout_oe), 16'h0000);
  endtask : frame
  task automatic abort_then_frame();
    int p0;
    p0 = pulses;
    tx_word <= 16'hffff;
    i_mst.xfer(16'hffff, 5, 25000);
    chk("partial", 16'(pulses - p0), 16'h0000);
    chk("dout_oe", 16'(dout_oe), 16'h0000);
    frame(8'h00, 16'h8001, 16'h1234, 10000);
  endtask : abort_then_frame
  initial begin
    arst_n = 1'b0;
    tx_word = 16'h0000;
    sample_period_setting = 8'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("rst_rx_word", rx_word, 16'h0000);
    chk("rst_dout_oe", 16'(dout_oe), 16'h0000);
    frame(8'h07, 16'ha5c3, 16'h3c96, 10000);
    frame(8'h08, 16'h5a3c, 16'hc369, 25000);
    abort_then_frame();
    summarize();
  end
  initial begin
    // frames plus spacing need about 71000 cycles
    repeat (90000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : isss_spi_slave_test
